// ==== shared/mtr_map.svh ====
// constants of the memory type range block: indices, field positions, reset values, encodings
`ifndef MTR_MAP_SVH
`define MTR_MAP_SVH
`define MTR_IDX_W 16
`define MTR_IDX_CAP 16'h0100
`define MTR_IDX_DEF 16'h0101
`define MTR_IDX_FIX64K 16'h0110
`define MTR_IDX_FIX16K_FIRST 16'h0111
`define MTR_IDX_FIX16K_SECOND 16'h0112
`define MTR_IDX_FIX4K_BASE 16'h0113
`define MTR_IDX_FIX4K_LAST 16'h011A
`define MTR_NUM_FIXED 11
`define MTR_CAP_VALUE 64'h0000_0000_0000_0508
`define MTR_VAR_COUNT 8'h08
`define MTR_CAP_FIX_BIT 8
`define MTR_CAP_WC_BIT 10
`define MTR_DEF_FE_BIT 10
`define MTR_DEF_E_BIT 11
`define MTR_DEF_RESET 64'h0000_0000_0000_0000
`define MTR_FIX_RESET 64'h0000_0000_0000_0000
`define MTR_FEATURE_RANGE_BIT 12
`define MTR_TYPE_UC 8'h00
`define MTR_TYPE_WC 8'h01
`define MTR_TYPE_WT 8'h04
`define MTR_TYPE_WP 8'h05
`define MTR_TYPE_WB 8'h06
`define MTR_ADDR_W 36
`endif

// ==== shared/mtr_pkg.sv ====
// types of the memory type range block
package mtr_pkg;
  typedef logic [7:0] mtr_type_t;
  typedef logic [63:0] mtr_word_t;
  typedef logic [15:0] mtr_idx_t;
  typedef enum logic [2:0] {
    MTR_IDLE = 3'b001,
    MTR_ANSWER = 3'b010,
    MTR_FAULT = 3'b100
  } mtr_state_e;
endpackage : mtr_pkg

// ==== shared/mtr_fix_if.sv ====
// carrier between the range register file and the fixed-range decoder
`timescale 1ns/1ns
interface mtr_fix_if;
  logic [63:0] fixed_regs [0:10];
  logic [35:0] addr;
  logic [7:0] fixed_type;
  logic below_1m;
  modport regs (output fixed_regs, output addr, input fixed_type, input below_1m);
  modport decode (input fixed_regs, input addr, output fixed_type, output below_1m);
endinterface : mtr_fix_if

// ==== rtl/mtr_fixed_decode.sv ====
// selects the fixed-range type field that covers a physical address
`timescale 1ns/1ns
module mtr_fixed_decode (
  mtr_fix_if.decode fix
);
  import mtr_pkg::*;
  logic [19:0] low;
  logic [3:0] reg_sel;
  logic [2:0] field_sel;
  logic [63:0] word;
  assign low = fix.addr[19:0];
  assign fix.below_1m = (fix.addr[35:20] == 16'h0000);
  always_comb begin
    if (low[19] == 1'b0) begin
      // 64 KiB slices of 0..7FFFF [RULE17]
      reg_sel = 4'h0;
      field_sel = low[18:16];
    end else if (low[18] == 1'b0) begin
      // 16 KiB slices of 80000..BFFFF, ascending across two registers [RULE18]
      reg_sel = {3'b000, low[17]} + 4'h1;
      field_sel = low[16:14];
    end else begin
      // 4 KiB slices of C0000..FFFFF, eight registers [RULE22]
      reg_sel = {1'b0, low[17:15]} + 4'h3;
      field_sel = low[14:12];
    end
  end
  assign word = fix.fixed_regs[reg_sel];
  // field k sits in bits 8k+7:8k and serves the k-th slice upward [RULE23]
  assign fix.fixed_type = word[{field_sel, 3'b000} +: 8];
endmodule : mtr_fixed_decode

// ==== rtl/mtr_range_top.sv ====
// memory type range register file with physical address type lookup
`timescale 1ns/1ns
`include "mtr_map.svh"
// Operation
// (RULE1) type codes 0,1,4,5,6; cacheability per code
// (RULE2) reserved type code faults, register kept
// (RULE3) after reset every address is uncached
// (RULE4) capability bits 7:0 report eight ranges
// (RULE5) capability bit 8 flags fixed ranges
// (RULE6) capability bit 10 flags write-combining
// (RULE7) capability write faults; bit 9 reserved
// (RULE8) capability always reads 508H
// (RULE9) range registers readable and writable
// (RULE10) default type covers unmapped or disabled
// (RULE11) default type field only legal codes
// (RULE12) bit 10 enables fixed ranges, fixed wins
// (RULE13) fixed disabled: variable ranges cover low
// (RULE14) bit 11 global enable, else default
// (RULE15) default register reserved bits nonzero fault
// (RULE16) fixed registers hold eight 8-bit fields
// (RULE17) first fixed register: eight 64K slices
// (RULE18) two registers: sixteen 16K slices ascending
// (RULE19) range write flushes all translation entries
// (RULE20) identification feature bit 12 set
// (RULE21) software should map absent memory uncached
// (RULE22) eight registers: sixty-four 4K slices
// (RULE23) field k serves k-th slice upward
// (RULE24) combinational lookup: fixed, variable, default
module mtr_range_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic model_register_read,
  input wire logic model_register_write,
  input wire mtr_pkg::mtr_idx_t reg_index,
  input wire mtr_pkg::mtr_word_t wr_data,
  output mtr_pkg::mtr_word_t rd_data,
  output logic rsp_valid,
  output logic general_protection_fault,
  output logic tlb_flush_all,
  output logic [31:0] feature_information_word,
  input wire logic [35:0] lookup_addr,
  input wire logic var_hit,
  input wire mtr_pkg::mtr_type_t var_type,
  output mtr_pkg::mtr_type_t lookup_type,
  output logic lookup_cacheable_rd,
  output logic lookup_cacheable_wr
);
  import mtr_pkg::*;

  mtr_word_t default_type_control;
  mtr_word_t fixed_range [0:`MTR_NUM_FIXED-1];
  mtr_state_e state;
  mtr_state_e next_state;
  mtr_word_t next_rd_data;
  logic wr_legal;
  logic idx_fixed;
  logic [3:0] fixed_sel;
  logic ranges_on;
  logic fixed_on;
  mtr_fix_if fix ();

  function automatic logic type_legal(input mtr_type_t t);
    case (t)
      `MTR_TYPE_UC, `MTR_TYPE_WC, `MTR_TYPE_WT, `MTR_TYPE_WP, `MTR_TYPE_WB: type_legal = 1'b1; // [RULE1]
      default: type_legal = 1'b0; // [RULE2]
    endcase
  endfunction : type_legal

  function automatic logic all_fields_legal(input mtr_word_t w);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 8; k++) begin
      ok = ok & type_legal(w[8*k +: 8]);
    end
    all_fields_legal = ok;
  endfunction : all_fields_legal

  // identification word: only the range support flag is this block's to report
  assign feature_information_word = 32'h0000_0001 << `MTR_FEATURE_RANGE_BIT; // [RULE20]

  assign idx_fixed = (reg_index >= `MTR_IDX_FIX64K) && (reg_index <= `MTR_IDX_FIX4K_LAST);
  assign fixed_sel = 4'(reg_index - `MTR_IDX_FIX64K);

  always_comb begin
    if (reg_index == `MTR_IDX_DEF) begin
      // type must be legal and bits 8,9,63:12 zero [RULE11] [RULE15]
      wr_legal = type_legal(wr_data[7:0]) && (wr_data[9:8] == 2'b00) && (wr_data[63:12] == 52'h0);
    end else if (idx_fixed) begin
      wr_legal = all_fields_legal(wr_data); // [RULE2] [RULE16]
    end else begin
      // capability and unmapped indices always fault [RULE7]
      wr_legal = 1'b0;
    end
  end

  // default register, cleared at reset so lookups fall to uncached [RULE3]
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      default_type_control <= `MTR_DEF_RESET;
    end else if (model_register_write && wr_legal && reg_index == `MTR_IDX_DEF) begin
      default_type_control <= wr_data; // [RULE9]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `MTR_NUM_FIXED; i++) begin
        fixed_range[i] <= `MTR_FIX_RESET;
      end
    end else if (model_register_write && wr_legal && idx_fixed) begin
      fixed_range[fixed_sel] <= wr_data; // [RULE9] [RULE16]
    end
  end

  always_comb begin
    next_rd_data = 64'h0;
    if (reg_index == `MTR_IDX_CAP) begin
      next_rd_data = `MTR_CAP_VALUE; // [RULE4] [RULE5] [RULE6] [RULE8]
    end else if (reg_index == `MTR_IDX_DEF) begin
      next_rd_data = default_type_control; // [RULE9]
    end else if (idx_fixed) begin
      next_rd_data = fixed_range[fixed_sel];
    end
  end

  always_comb begin
    if (model_register_write) begin
      next_state = wr_legal ? MTR_ANSWER : MTR_FAULT;
    end else if (model_register_read) begin
      // reads of unmapped indices fault too
      next_state = (reg_index == `MTR_IDX_CAP || reg_index == `MTR_IDX_DEF || idx_fixed) ? MTR_ANSWER : MTR_FAULT;
    end else begin
      next_state = MTR_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= MTR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 64'h0;
    end else if (model_register_read && !model_register_write) begin
      rd_data <= next_rd_data;
    end
  end

  always_comb begin
    case (state)
      MTR_ANSWER: begin
        rsp_valid = 1'b1;
        general_protection_fault = 1'b0;
      end
      MTR_FAULT: begin
        rsp_valid = 1'b1;
        general_protection_fault = 1'b1; // [RULE2] [RULE7]
      end
      default: begin
        rsp_valid = 1'b0;
        general_protection_fault = 1'b0;
      end
    endcase
  end

  // any accepted range write drops global translation entries as well
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tlb_flush_all <= 1'b0;
    end else begin
      tlb_flush_all <= model_register_write && wr_legal; // [RULE19]
    end
  end

  always_comb begin
    for (int i = 0; i < `MTR_NUM_FIXED; i++) begin
      fix.fixed_regs[i] = fixed_range[i];
    end
  end
  assign fix.addr = lookup_addr;

  mtr_fixed_decode u_fixed_decode (
    .fix(fix.decode)
  );

  assign ranges_on = default_type_control[`MTR_DEF_E_BIT]; // [RULE14]
  assign fixed_on = ranges_on && default_type_control[`MTR_DEF_FE_BIT]; // [RULE12]

  // lookup is combinational so the core can use it in the same cycle
  always_comb begin
    if (!ranges_on) begin
      lookup_type = default_type_control[7:0]; // [RULE10] [RULE14]
    end else if (fixed_on && fix.below_1m) begin
      lookup_type = fix.fixed_type; // [RULE12] [RULE24]
    end else if (var_hit) begin
      lookup_type = var_type; // [RULE13] [RULE24]
    end else begin
      lookup_type = default_type_control[7:0]; // [RULE10]
    end
  end

  // write-protected caches reads only
  assign lookup_cacheable_rd = (lookup_type == `MTR_TYPE_WT) || (lookup_type == `MTR_TYPE_WP)
                               || (lookup_type == `MTR_TYPE_WB); // [RULE1]
  assign lookup_cacheable_wr = (lookup_type == `MTR_TYPE_WT) || (lookup_type == `MTR_TYPE_WB); // [RULE1]

  logic range_written;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      range_written <= 1'b0;
    end else if (model_register_write) begin
      range_written <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_CAP_READ: assert property ( // [RULE8]
    (model_register_read && !model_register_write && reg_index == `MTR_IDX_CAP)
    |=> rsp_valid && !general_protection_fault && rd_data == 64'h0000_0000_0000_0508)
    else $error("capability read did not return 508H");
  AST_CAP_WRITE: assert property ( // [RULE7]
    (model_register_write && reg_index == `MTR_IDX_CAP) |=> rsp_valid && general_protection_fault && !tlb_flush_all)
    else $error("capability write did not fault");
  AST_BAD_DEF_TYPE: assert property ( // [RULE2]
    (model_register_write && reg_index == `MTR_IDX_DEF && !type_legal(wr_data[7:0]))
    |=> general_protection_fault && $stable(default_type_control))
    else $error("reserved default type accepted");
  AST_DEF_RSVD: assert property ( // [RULE15]
    (model_register_write && reg_index == `MTR_IDX_DEF && (wr_data[9:8] != 2'b00 || wr_data[63:12] != 52'h0))
    |=> general_protection_fault)
    else $error("default register reserved bits accepted");
  AST_FLUSH: assert property ( // [RULE19]
    (model_register_write && idx_fixed && all_fields_legal(wr_data))
    |=> tlb_flush_all && !general_protection_fault)
    else $error("range write without flush pulse");
  // back to back writes may keep the flush high, so tie each flush cycle to its own write
  AST_FLUSH_CAUSE: assert property ( // [RULE19]
    tlb_flush_all |-> $past(model_register_write) && $past(wr_legal))
    else $error("flush pulse without accepted range write");
  AST_DEF_READBACK: assert property ( // [RULE9]
    (model_register_write && reg_index == `MTR_IDX_DEF && wr_legal) ##1
    (model_register_read && !model_register_write && reg_index == `MTR_IDX_DEF)
    |=> rd_data == $past(wr_data, 2))
    else $error("default register read back differs");
  AST_GLOBAL_OFF: assert property ( // [RULE14]
    !default_type_control[11] |-> lookup_type == default_type_control[7:0])
    else $error("ranges applied while globally disabled");
  AST_FIXED_PRIO: assert property ( // [RULE12]
    (default_type_control[11] && default_type_control[10] && lookup_addr[35:20] == 16'h0000)
    |-> lookup_type == fix.fixed_type)
    else $error("fixed range lost priority");
  AST_FE_OFF: assert property ( // [RULE13]
    (default_type_control[11] && !default_type_control[10] && var_hit) |-> lookup_type == var_type)
    else $error("variable range ignored with fixed disabled");
  AST_RESET_UC: assert property ( // [RULE3]
    !range_written |-> lookup_type == 8'h00 && !lookup_cacheable_rd)
    else $error("address not uncached after reset");
  AST_WP_READONLY: assert property ( // [RULE1]
    (lookup_type == 8'h05) |-> lookup_cacheable_rd && !lookup_cacheable_wr)
    else $error("write-protected cacheability wrong");
  AST_UNCACHED: assert property ( // [RULE1]
    (lookup_type == `MTR_TYPE_UC || lookup_type == `MTR_TYPE_WC)
    |-> !lookup_cacheable_rd && !lookup_cacheable_wr)
    else $error("uncached or combining type marked cacheable");
  AST_DEF_TYPE_LEGAL: assert property ( // [RULE11]
    type_legal(default_type_control[7:0]))
    else $error("default register holds a reserved type");
  AST_DEF_RSVD_ZERO: assert property ( // [RULE15]
    default_type_control[9:8] == 2'b00 && default_type_control[63:12] == 52'h0)
    else $error("default register reserved bits set");
  AST_FIX_FIELD_LEGAL: assert property ( // [RULE2]
    type_legal(fix.fixed_type))
    else $error("fixed register holds a reserved type");
  AST_FIX_BAD: assert property ( // [RULE2]
    (model_register_write && idx_fixed && !all_fields_legal(wr_data))
    |=> general_protection_fault && !tlb_flush_all)
    else $error("reserved fixed type accepted");
  AST_FIX_READBACK: assert property ( // [RULE16]
    (model_register_write && idx_fixed && wr_legal) ##1
    (model_register_read && !model_register_write && reg_index == $past(reg_index))
    |=> rd_data == $past(wr_data, 2))
    else $error("fixed register read back differs");
  AST_CAP_COUNT: assert property ( // [RULE4]
    (model_register_read && !model_register_write && reg_index == `MTR_IDX_CAP) |=> rd_data[7:0] == 8'h08)
    else $error("capability range count wrong");
  AST_CAP_FIXED: assert property ( // [RULE5]
    (model_register_read && !model_register_write && reg_index == `MTR_IDX_CAP) |=> rd_data[8])
    else $error("capability fixed flag clear");
  AST_CAP_WC: assert property ( // [RULE6]
    (model_register_read && !model_register_write && reg_index == `MTR_IDX_CAP) |=> rd_data[10])
    else $error("capability combining flag clear");
  AST_ANSWER: assert property ( // [RULE9]
    (model_register_read || model_register_write) |=> rsp_valid)
    else $error("access not answered in the next cycle");
  AST_IDLE_QUIET: assert property ( // [RULE9]
    !(model_register_read || model_register_write) |=> !rsp_valid && !general_protection_fault && !tlb_flush_all)
    else $error("answer without access");
  // slice checks index the register file directly, independent of the decoder
  AST_MAP_64K: assert property ( // [RULE17]
    (fixed_on && lookup_addr[35:19] == 17'h00000)
    |-> lookup_type == fixed_range[0][{lookup_addr[18:16], 3'b000} +: 8])
    else $error("64K slice mapped to wrong field");
  AST_MAP_16K: assert property ( // [RULE18]
    (fixed_on && lookup_addr[35:18] == 18'h00002)
    |-> lookup_type == fixed_range[{3'b000, lookup_addr[17]} + 4'h1][{lookup_addr[16:14], 3'b000} +: 8])
    else $error("16K slice mapped to wrong field");
  AST_MAP_4K: assert property ( // [RULE22]
    (fixed_on && lookup_addr[35:18] == 18'h00003)
    |-> lookup_type == fixed_range[{1'b0, lookup_addr[17:15]} + 4'h3][{lookup_addr[14:12], 3'b000} +: 8])
    else $error("4K slice mapped to wrong field");

  COV_FIXED_HIT: cover property (fixed_on && fix.below_1m && lookup_type == `MTR_TYPE_WB);
  COV_FAULT: cover property (general_protection_fault);
  COV_FLUSH: cover property (tlb_flush_all);
  COV_VAR_HIT: cover property (ranges_on && !fix.below_1m && var_hit);
endmodule : mtr_range_top

// ==== tb/mtr_core_model.sv ====
// model of the core's model register access path
`timescale 1ns/1ns
module mtr_core_model (
  input wire logic sys_clk,
  input wire logic rsp_valid,
  input wire logic general_protection_fault,
  input wire logic tlb_flush_all,
  input wire mtr_pkg::mtr_word_t rd_data,
  output logic model_register_read,
  output logic model_register_write,
  output mtr_pkg::mtr_idx_t reg_index,
  output mtr_pkg::mtr_word_t wr_data
);
  import mtr_pkg::*;
  initial begin
    model_register_read = 1'b0;
    model_register_write = 1'b0;
    reg_index = 16'h0000;
    wr_data = 64'h0;
  end
  // one pulse per call; index and data invert once released so a stale value never looks valid
  task access(input logic wr, input mtr_idx_t idx, input mtr_word_t d, output mtr_word_t q, output logic [2:0] st);
    @(posedge sys_clk);
    #1;
    model_register_write = wr;
    model_register_read = !wr;
    reg_index = idx;
    wr_data = d;
    @(posedge sys_clk);
    #1;
    model_register_write = 1'b0;
    model_register_read = 1'b0;
    reg_index = ~idx;
    wr_data = ~d;
    q = rd_data;
    st = {rsp_valid, general_protection_fault, tlb_flush_all};
  endtask : access
  // write, then read the same index in the very next cycle
  task pair(input mtr_idx_t idx, input mtr_word_t d, output mtr_word_t q, output logic [2:0] sw,
    output logic [2:0] sr);
    @(posedge sys_clk);
    #1;
    model_register_write = 1'b1;
    model_register_read = 1'b0;
    reg_index = idx;
    wr_data = d;
    @(posedge sys_clk);
    #1;
    sw = {rsp_valid, general_protection_fault, tlb_flush_all};
    model_register_write = 1'b0;
    model_register_read = 1'b1;
    wr_data = ~d;
    @(posedge sys_clk);
    #1;
    model_register_read = 1'b0;
    reg_index = ~idx;
    q = rd_data;
    sr = {rsp_valid, general_protection_fault, tlb_flush_all};
  endtask : pair
endmodule : mtr_core_model

// ==== tb/memory_type_range_lookup_test.sv ====
// self-checking bench of the memory type range block
`timescale 1ns/1ns
`include "mtr_map.svh"
module memory_type_range_lookup_test;
  import mtr_pkg::*;
  logic sys_clk, nrst, rsp_valid, general_protection_fault, tlb_flush_all, var_hit;
  logic model_register_read, model_register_write, lookup_cacheable_rd, lookup_cacheable_wr;
  mtr_idx_t reg_index;
  mtr_word_t wr_data, rd_data, q, def, f64, fa, fb, f4;
  logic [2:0] st;
  logic [31:0] feature_information_word;
  logic [35:0] lookup_addr;
  mtr_type_t var_type, lookup_type, t;
  int errors, checks, seed, i, m;
  int rsv [4] = '{8, 9, 12, 63};
  mtr_word_t modes [3] = '{64'hC00, 64'h806, 64'h405};
  logic [35:0] edges [11] = '{36'h7FFFF, 36'h80000, 36'h9FFFF, 36'hA0000, 36'hA4000, 36'hBFFFF, 36'hC0000,
    36'hF7FFF, 36'hF8000, 36'hFFFFF, 36'h100000};
  mtr_range_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .model_register_read(model_register_read),
    .model_register_write(model_register_write), .reg_index(reg_index), .wr_data(wr_data), .rd_data(rd_data),
    .rsp_valid(rsp_valid), .general_protection_fault(general_protection_fault), .tlb_flush_all(tlb_flush_all),
    .feature_information_word(feature_information_word), .lookup_addr(lookup_addr), .var_hit(var_hit),
    .var_type(var_type), .lookup_type(lookup_type), .lookup_cacheable_rd(lookup_cacheable_rd),
    .lookup_cacheable_wr(lookup_cacheable_wr));
  mtr_core_model i_core (.sys_clk(sys_clk), .rsp_valid(rsp_valid), .general_protection_fault(general_protection_fault),
    .tlb_flush_all(tlb_flush_all), .rd_data(rd_data), .model_register_read(model_register_read),
    .model_register_write(model_register_write), .reg_index(reg_index), .wr_data(wr_data));
  function automatic mtr_type_t legal(int r);
    case ({r} % 5)
      0: return 8'h00;
      1: return 8'h01;
      2: return 8'h04;
      3: return 8'h05;
      default: return 8'h06;
    endcase
  endfunction : legal
  function automatic mtr_word_t rnd_fix();
    mtr_word_t w;
    for (int k = 0; k < 8; k++) w[8*k +: 8] = legal($random(seed));
    return w;
  endfunction : rnd_fix
  // fixed slices: 64K below 80000, 16K up to C0000; only the last 4K register is written
  function automatic mtr_type_t exp_type(logic [35:0] a);
    if (!def[11]) return def[7:0];
    if (def[10] && a < 36'h100000) begin
      if (a < 36'h80000) return f64[8*a[18:16] +: 8];
      if (a < 36'hA0000) return fa[8*a[16:14] +: 8];
      if (a < 36'hC0000) return fb[8*a[16:14] +: 8];
      if (a >= 36'hF8000) return f4[8*a[14:12] +: 8];
      return 8'h00;
    end
    return var_hit ? var_type : def[7:0];
  endfunction : exp_type
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task look(input logic [35:0] a);
    @(posedge sys_clk);
    #1;
    lookup_addr = a;
    var_hit = 1'($random(seed));
    var_type = legal($random(seed));
    #1;
    t = exp_type(a);
    chk("lookup_type", lookup_type, t);
    chk("cacheable_rd", lookup_cacheable_rd, t inside {8'h04, 8'h05, 8'h06});
    chk("cacheable_wr", lookup_cacheable_wr, t inside {8'h04, 8'h06});
  endtask : look
  // status is {answer, fault, flush}
  task acc(input logic wr, input mtr_idx_t idx, input mtr_word_t d, input logic [2:0] es, input mtr_word_t eq);
    i_core.access(wr, idx, d, q, st);
    chk("status", st, es);
    if (!wr) chk("rd_data", q, eq);
  endtask : acc
  // back to back write and read: the read must already see the new value
  task acc2(input mtr_idx_t idx, input mtr_word_t d);
    logic [2:0] sw;
    i_core.pair(idx, d, q, sw, st);
    chk("pair_wr_status", sw, 3'h5);
    chk("pair_rd_status", st, 3'h4);
    chk("pair_rd_data", q, d);
  endtask : acc2
  task wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    checks = 0;
    seed = 77250;
    nrst = 1'b0;
    lookup_addr = 36'h0;
    var_hit = 1'b0;
    var_type = 8'h00;
    def = 64'h0;
    f64 = 64'h0;
    fa = 64'h0;
    fb = 64'h0;
    f4 = 64'h0;
    repeat (6) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    for (i = 0; i < 8; i++) look(36'({$random(seed)} % 32'h100000));
    chk("feature", feature_information_word[12], 1'b1);
    acc(0, `MTR_IDX_CAP, 64'h0, 3'h4, 64'h508);
    acc(1, `MTR_IDX_CAP, 64'h0, 3'h6, 64'h0);
    acc(0, `MTR_IDX_CAP, 64'h0, 3'h4, 64'h508);
    chk("var_count", q[7:0], 8'h08);
    chk("fixed_flag", q[8], 1'b1);
    chk("wc_flag", q[10], 1'b1);
    for (i = 0; i < 10; i++) begin
      t = (i == 9) ? 8'hFF : i[7:0];
      if (t inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06}) begin
        acc(1, `MTR_IDX_DEF, {56'h0, t}, 3'h5, 64'h0);
        def = {56'h0, t};
      end else begin
        acc(1, `MTR_IDX_DEF, {56'h0, t}, 3'h6, 64'h0);
      end
      acc(0, `MTR_IDX_DEF, 64'h0, 3'h4, def);
      look({4'h0, $random(seed)});
    end
    foreach (rsv[k]) acc(1, `MTR_IDX_DEF, def | (64'h1 << rsv[k]), 3'h6, 64'h0);
    acc(0, `MTR_IDX_DEF, 64'h0, 3'h4, def);
    f64 = rnd_fix();
    fa = rnd_fix();
    fb = rnd_fix();
    f4 = rnd_fix();
    acc(1, `MTR_IDX_FIX64K, f64, 3'h5, 64'h0);
    acc(1, `MTR_IDX_FIX16K_FIRST, fa, 3'h5, 64'h0);
    acc(1, `MTR_IDX_FIX16K_SECOND, fb, 3'h5, 64'h0);
    acc2(`MTR_IDX_FIX4K_LAST, f4);
    acc(1, `MTR_IDX_FIX64K, f64 | (64'h07 << (8 * ({$random(seed)} % 8))), 3'h6, 64'h0);
    acc(0, `MTR_IDX_FIX64K, 64'h0, 3'h4, f64);
    acc(0, `MTR_IDX_FIX16K_SECOND, 64'h0, 3'h4, fb);
    acc(1, 16'h0200, 64'h0, 3'h6, 64'h0);
    acc(0, 16'h0200, 64'h0, 3'h6, 64'h0);
    // default type uncached only in the first mode; the other two default to write-back and write-protected
    for (m = 0; m < 3; m++) begin
      def = modes[m];
      acc(1, `MTR_IDX_DEF, def, 3'h5, 64'h0);
      foreach (edges[k]) look(edges[k]);
      for (i = 0; i < 40; i++) look(36'({$random(seed)} % 32'hC0000));
      for (i = 0; i < 8; i++) look(36'h0C0000 + 36'({$random(seed)} % 32'h40000));
      for (i = 0; i < 6; i++) look({4'h1, $random(seed)});
    end
    def = 64'hC06;
    acc2(`MTR_IDX_DEF, def);
    foreach (edges[k]) look(edges[k]);
    @(posedge sys_clk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    def = 64'h0;
    acc(0, `MTR_IDX_FIX64K, 64'h0, 3'h4, 64'h0);
    look(36'h12345);
    wrap_up();
  end
endmodule : memory_type_range_lookup_test
